// ==== src/icp_phase_seq.v ====
// Four-phase instruction-cycle sequencer with fetch/execute overlap.
// Assumes program memory answers combinationally within the fetch phase.
// Functional notes
// RULE1: Each instruction cycle is split into four non-overlapping phases, fetch then three execute phases.
// RULE2: At the start of the fetch phase the program counter advances and the next fetch begins; the code advances it at the end of fetch.
// RULE3: Decode and execute happen in the second, third and fourth phases.
// RULE4: One pass through the four phases is one instruction cycle of four clock periods.
// RULE5: Fetch of the next instruction overlaps execution of the current one.
// RULE6: A program counter changing instruction takes two cycles and discards the prefetched word.
// RULE7: In RC mode the phase sync pin carries the fetch phase, one high and three low clocks.
// RULE8: On wake from halt execution waits for a 1024-clock start-up count.
// RULE9: The datapath uses an eight-bit accumulator and ALU.
// RULE10: After reset the first cycle begins with the fetch phase.
// RULE11: While halted the sequencer stops and resumes at fetch after the start-up delay.
`timescale 1ns/1ps
`include "icp_consts.vh"
module icp_phase_seq #(
	parameter DATA_W      = `ICP_DATA_W,
	parameter PC_W        = `ICP_PC_W,
	parameter INSTR_W     = `ICP_INSTR_W,
	parameter STARTUP_CYC = `ICP_STARTUP_CYC
) (
	// Clock and reset
	input  wire               clock_in,
	input  wire               reset_n_in,
	// Options and control
	input  wire               rc_mode_in,
	input  wire               halt_req_in,
	input  wire               wake_in,
	// Program memory
	input  wire [INSTR_W-1:0] pmem_data_in,
	output reg  [PC_W-1:0]    pmem_addr_out,
	output reg                pmem_read_out,
	// Decoded instruction from core
	input  wire               branch_in,
	input  wire [PC_W-1:0]    branch_target_in,
	input  wire [2:0]         alu_op_in,
	input  wire [DATA_W-1:0]  alu_operand_in,
	// Phase outputs
	output reg                fetch_phase_out,
	output reg                execute_phases_out,
	output reg  [1:0]         phase_out,
	output reg                instr_done_out,
	output reg                halted_out,
	output reg  [INSTR_W-1:0] instr_out,
	output reg  [DATA_W-1:0]  acc_out,
	// Phase sync pin
	output reg                phase_sync_pin_out,
	output reg                phase_sync_pin_oe_out
);
	localparam ST_RUN  = 2'h0;
	localparam ST_HALT = 2'h1;
	localparam ST_WAKE = 2'h2;
	localparam CNT_W = 11;
	// Start-up count limit, cut to the counter width on purpose
	localparam [31:0]      WAKE_LAST_W = STARTUP_CYC - 1;
	localparam [CNT_W-1:0] WAKE_LAST   = WAKE_LAST_W[CNT_W-1:0];

	reg  [1:0]         state;
	reg  [1:0]         phase;
	reg  [PC_W-1:0]    pc;
	reg  [CNT_W-1:0]   wake_cnt;
	reg                branch_pend;
	reg  [PC_W-1:0]    target;
	reg  [DATA_W-1:0]  acc;
	reg  [1:0]         next_state;
	reg  [1:0]         next_phase;
	wire               running;
	wire               at_fetch;
	wire               next_fetch;
	wire               capture;
	wire               flush;
	wire [INSTR_W-1:0] held_word;
	wire               held_valid;

	// Eight-bit ALU
	function [DATA_W-1:0] alu;
		input [2:0]        op;
		input [DATA_W-1:0] a;
		input [DATA_W-1:0] b;
		begin
			case (op)
				3'h0: alu = a + b;
				3'h1: alu = a - b;
				3'h2: alu = a & b;
				3'h3: alu = a | b;
				3'h4: alu = a ^ b;
				3'h5: alu = ~a;
				3'h6: alu = {a[DATA_W-2:0], a[DATA_W-1]};
				default: alu = b;
			endcase
		end
	endfunction

	// Fetch decode, shared by the current and the next phase
	function fetch_next;
		input [1:0] st;
		input [1:0] ph;
		begin
			fetch_next = (st == ST_RUN) && (ph == `ICP_PHASE_FETCH);
		end
	endfunction

	assign running    = (state == ST_RUN);
	assign at_fetch   = fetch_next(state, phase);
	assign next_fetch = fetch_next(next_state, next_phase);
	// RULE5: prefetch during execution
	assign capture  = at_fetch;
	// RULE6: discard prefetched word
	assign flush    = running && (phase == `ICP_PHASE_EXEC3) && held_valid && branch_in && !branch_pend;

	icp_fetch_reg #(
		.INSTR_W (INSTR_W)
	) u_fetch (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.capture_in (capture),
		.flush_in   (flush | branch_pend),
		.word_in    (pmem_data_in),
		.word_out   (held_word),
		.valid_out  (held_valid)
	);

	// RULE8: halt and start-up state
	always @* begin
		next_state = state;
		case (state)
			// Halt waits for the instruction boundary; the instruction in hand still completes
			ST_RUN: begin
				if (halt_req_in && phase == `ICP_PHASE_EXEC3)
					next_state = ST_HALT;
			end
			ST_HALT: begin
				if (wake_in)
					next_state = ST_WAKE;
			end
			// Start-up count runs from the clock after the wake event
			ST_WAKE: begin
				if (wake_cnt == WAKE_LAST)
					next_state = ST_RUN;
			end
			default: next_state = ST_RUN;
		endcase
	end

	// RULE1: four phase rotation
	// RULE4: four clocks per cycle
	// RULE11: frozen while halted
	always @* begin
		next_phase = phase;
		if (!running || next_state != ST_RUN)
			next_phase = `ICP_PHASE_FETCH;
		else
			next_phase = phase + 2'h1;
	end

	always @(posedge clock_in) begin
		if (!reset_n_in) begin
			// RULE10: start at fetch
			// Parked in the last phase so the first edge after release enters fetch
			state       <= ST_RUN;
			phase       <= `ICP_PHASE_EXEC3;
			wake_cnt    <= {CNT_W{1'b0}};
			pc          <= `ICP_PC_RESET;
			branch_pend <= 1'b0;
			target      <= `ICP_PC_RESET;
			acc         <= `ICP_ACC_RESET;
		end else begin
			state <= next_state;
			phase <= next_phase;
			if (state == ST_WAKE)
				wake_cnt <= wake_cnt + 11'h001;
			else
				wake_cnt <= {CNT_W{1'b0}};
			// RULE2: advance program counter at fetch
			// The discarded fetch of a branch loads the target for the next cycle
			if (at_fetch)
				pc <= branch_pend ? target : pc + 1'b1;
			// RULE6: first cycle obtains target
			if (flush) begin
				branch_pend <= 1'b1;
				target      <= branch_target_in;
			end else if (at_fetch) begin
				branch_pend <= 1'b0;
			end
			// RULE3: execute in last phases
			// RULE9: eight-bit accumulator datapath
			if (running && phase == `ICP_PHASE_EXEC3 && held_valid && !branch_in)
				acc <= alu(alu_op_in, acc, alu_operand_in);
		end
	end

	// Registered outputs
	always @(posedge clock_in) begin
		if (!reset_n_in) begin
			pmem_addr_out         <= `ICP_PC_RESET;
			pmem_read_out         <= 1'b0;
			fetch_phase_out       <= 1'b0;
			execute_phases_out    <= 1'b0;
			phase_out             <= `ICP_PHASE_FETCH;
			instr_done_out        <= 1'b0;
			halted_out            <= 1'b0;
			instr_out             <= {INSTR_W{1'b0}};
			acc_out               <= `ICP_ACC_RESET;
			phase_sync_pin_out    <= 1'b0;
			phase_sync_pin_oe_out <= 1'b0;
		end else begin
			// Address follows the counter; a branch's dummy fetch reads the sequential word
			pmem_addr_out      <= pc;
			pmem_read_out      <= next_fetch;
			fetch_phase_out    <= next_fetch;
			execute_phases_out <= (next_state == ST_RUN) && (next_phase != `ICP_PHASE_FETCH);
			phase_out          <= next_phase;
			instr_done_out     <= running && phase == `ICP_PHASE_EXEC3 && held_valid && !branch_in;
			halted_out         <= (next_state != ST_RUN);
			instr_out          <= held_word;
			acc_out            <= acc;
			// RULE7: fetch phase on sync pin
			phase_sync_pin_out    <= rc_mode_in && next_fetch;
			phase_sync_pin_oe_out <= rc_mode_in;
		end
	end
endmodule // icp_phase_seq

// ==== src/icp_consts.vh ====
// Constants of the instruction-cycle phase timing block.
// Included by the sequencer and its fetch register module.
`ifndef ICP_CONSTS_VH
`define ICP_CONSTS_VH
// Phase codes
`define ICP_PHASE_FETCH   2'h0
`define ICP_PHASE_EXEC1   2'h1
`define ICP_PHASE_EXEC2   2'h2
`define ICP_PHASE_EXEC3   2'h3
// Phases per instruction cycle
`define ICP_PHASES        4
// Start-up timer, in system clock periods
`define ICP_STARTUP_TSYS  1024
`define ICP_STARTUP_CYC   (`ICP_STARTUP_TSYS * 1)
// Widths and reset values
`define ICP_DATA_W        8
`define ICP_PC_W          11
`define ICP_INSTR_W       15
`define ICP_PC_RESET      11'h000
`define ICP_ACC_RESET     8'h00
`endif

// ==== src/icp_fetch_reg.v ====
// Instruction fetch register: captures the fetched word and can flush it.
// Assumes program memory data are valid when the capture strobe is high.
`timescale 1ns/1ps
`include "icp_consts.vh"
module icp_fetch_reg #(
	parameter INSTR_W = `ICP_INSTR_W
) (
	// Clock and reset
	input  wire               clock_in,
	input  wire               reset_n_in,
	// Capture and flush
	input  wire               capture_in,
	input  wire               flush_in,
	input  wire [INSTR_W-1:0] word_in,
	// Held word
	output reg  [INSTR_W-1:0] word_out,
	output reg                valid_out
);
	always @(posedge clock_in) begin
		if (!reset_n_in) begin
			word_out  <= {INSTR_W{1'b0}};
			valid_out <= 1'b0;
		end else if (capture_in) begin
			word_out  <= word_in;
			valid_out <= ~flush_in;
		end else if (flush_in) begin
			valid_out <= 1'b0;
		end
	end
endmodule // icp_fetch_reg

// ==== verification/icp_phase_seq_properties.sv ====
// Port checker for the phase sequencer, bound to every instance.
// Assumes the core never flags a branch in two consecutive cycles.
`timescale 1ns/1ps
module icp_checker #(parameter int STARTUP_CYC = 8) (
	input wire        clock_in, reset_n_in, rc_mode_in, halt_req_in, wake_in, branch_in,
	input wire        fetch_phase_out, execute_phases_out, instr_done_out, halted_out,
	input wire        phase_sync_pin_out, phase_sync_pin_oe_out,
	input wire [10:0] branch_target_in, pmem_addr_out,
	input wire [1:0]  phase_out
);
	localparam int WAKE_MAX = STARTUP_CYC + 4;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	a_phase_code: assert property ($past(reset_n_in, 3) && !halted_out |->
		fetch_phase_out == (phase_out == 2'h0) && execute_phases_out == (phase_out != 2'h0)) else $error("bad phase flags");
	a_phase_walk: assert property (fetch_phase_out |=>
		phase_out == 2'h1 ##1 phase_out == 2'h2 ##1 phase_out == 2'h3) else $error("bad phase order");
	a_pc_step: assert property (phase_out == 2'h3 && !branch_in && !halt_req_in && !halted_out ##4
		phase_out == 2'h3 && !branch_in ##1 fetch_phase_out |-> pmem_addr_out == $past(pmem_addr_out, 4) + 11'h001)
		else $error("address not stepped");
	a_branch_tgt: assert property (
		phase_out == 2'h3 && branch_in && !halt_req_in && !halted_out && !$past(branch_in, 4) |->
		##5 fetch_phase_out && pmem_addr_out == $past(branch_target_in, 5)) else $error("target not fetched");
	a_done_cause: assert property (instr_done_out |-> $past(phase_out) == 2'h3 && !$past(branch_in))
		else $error("stray done pulse");
	a_sync_pin: assert property ($past(reset_n_in, 2) && rc_mode_in == $past(rc_mode_in) |->
		phase_sync_pin_oe_out == rc_mode_in && phase_sync_pin_out == (rc_mode_in && fetch_phase_out))
		else $error("bad sync pin");
	a_halt_entry: assert property (phase_out == 2'h3 && halt_req_in && !halted_out |=>
		halted_out && !fetch_phase_out ##1 halted_out && !fetch_phase_out && !instr_done_out)
		else $error("halt not entered");
	a_wake_delay: assert property ($rose(wake_in) && halted_out |->
		##[STARTUP_CYC:WAKE_MAX] $fell(halted_out) && fetch_phase_out) else $error("bad start-up delay");
	c_branch: cover property (phase_out == 2'h3 && branch_in);
	c_wake: cover property ($fell(halted_out));
	c_done: cover property (instr_done_out ##4 instr_done_out);
endmodule // icp_checker
bind icp_phase_seq icp_checker #(.STARTUP_CYC(STARTUP_CYC)) icp_checker_i (.*);

// ==== verification/instruction_cycle_phase_timing_tb.sv ====
// Random bench for the phase sequencer with halt, wake and resets.
// Assumes the start-up count is shortened to 8 clocks.
`timescale 1ns/1ps
module instruction_cycle_phase_timing_tb;
	reg         clock_in = 0, reset_n_in = 0, rc_mode_in = 0, halt_req_in = 0, wake_in = 0, branch_in = 0;
	reg  [14:0] pmem_data_in = 0, wd = 0;
	reg  [10:0] branch_target_in = 0, exp_pc = 0, tgt = 0;
	reg  [7:0]  alu_operand_in = 0, acc_m = 0, opd;
	reg  [2:0]  alu_op_in = 0, op;
	reg  [15:0] rnd = 16'hE4FD;
	reg         br = 0, dummy = 0, tcy = 0, plain = 0, dchk = 0, hl;
	integer     err_count = 0, tests_run = 0, skip = 2, n, k;
	wire [10:0] addr;
	wire [7:0]  acc;
	wire [1:0]  ph;
	wire [14:0] word;
	wire        fetch, exec, done, halted, sync, sync_oe, rd;
	always #2 clock_in = ~clock_in;
	icp_phase_seq #(.STARTUP_CYC(8)) icp_phase_seq_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.rc_mode_in(rc_mode_in), .halt_req_in(halt_req_in), .wake_in(wake_in), .pmem_data_in(pmem_data_in),
		.pmem_addr_out(addr), .pmem_read_out(rd), .branch_in(branch_in), .branch_target_in(branch_target_in),
		.alu_op_in(alu_op_in), .alu_operand_in(alu_operand_in), .fetch_phase_out(fetch), .execute_phases_out(exec),
		.phase_out(ph), .instr_done_out(done), .halted_out(halted), .instr_out(word), .acc_out(acc),
		.phase_sync_pin_out(sync), .phase_sync_pin_oe_out(sync_oe));
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function [7:0] alu_ref(input [2:0] o, input [7:0] a, input [7:0] b);
		case (o)
			3'h0: alu_ref = a + b;
			3'h1: alu_ref = a - b;
			3'h2: alu_ref = a & b;
			3'h3: alu_ref = a | b;
			3'h4: alu_ref = a ^ b;
			3'h5: alu_ref = ~a;
			3'h6: alu_ref = {a[6:0], a[7]};
			default: alu_ref = b;
		endcase
	endfunction
	task check(input [14:0] seen, input [14:0] exp, input string what);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task do_reset(input rc);
		begin
			@(posedge clock_in);
			reset_n_in <= 0;
			rc_mode_in <= rc;
			repeat (10) @(posedge clock_in);
			reset_n_in <= 1;
			{exp_pc, acc_m, dummy, tcy, dchk} = 0;
			skip = 2;
			for (k = 0; fetch !== 1'b1 && k < 20; k = k + 1) @(negedge clock_in);
		end
	endtask
	// One instruction cycle, entered at the fetch-phase falling edge
	task icyc(input h);
		begin
			hl = h && !dummy;
			check({fetch, rd}, 2'h3, "fetch");
			check({sync_oe, sync}, {2{rc_mode_in}}, "sync");
			if (dchk) check(done, plain, "done");
			if (!dummy) check(addr, exp_pc, "addr");
			rnd = lfsr(rnd);
			br = !hl && !dummy && rnd[2];
			plain = !br && !dummy && !tcy && !hl && skip == 0;
			op = plain ? {rnd[1:0], rnd[3]} : 3'h7;
			wd = pmem_data_in;
			opd = plain ? rnd[12:5] : acc_m;
			@(posedge clock_in);
			branch_in <= br;
			branch_target_in <= rnd[15:5];
			halt_req_in <= hl;
			pmem_data_in <= rnd[14:0];
			alu_op_in <= op;
			alu_operand_in <= opd;
			repeat (3) @(negedge clock_in);
			check({ph, exec, rd}, 4'hE, "phase");
			check(acc, acc_m, "acc");
			check(word, wd, "word");
			if (plain) acc_m = alu_ref(op, acc_m, opd);
			exp_pc = dummy ? tgt : exp_pc + 11'h001;
			dchk = plain || br || dummy;
			tcy = dummy;
			dummy = br;
			if (br) tgt = rnd[15:5];
			if (skip > 0) skip = skip - 1;
			@(negedge clock_in);
			if (hl) begin
				check({halted, fetch, rd}, 3'h4, "halt");
				@(posedge clock_in);
				halt_req_in <= 0;
				repeat (4) @(posedge clock_in);
				wake_in <= 1;
				@(posedge clock_in);
				wake_in <= 0;
				for (k = 0; fetch !== 1'b1 && k < 30; k = k + 1) @(negedge clock_in);
				check(k > 7 && k < 16, 1, "wake");
				skip = 1;
			end
		end
	endtask
	initial begin
		do_reset(0);
		for (n = 0; n < 300; n = n + 1) begin
			if (n == 150) do_reset(1);
			icyc(n % 97 == 50);
		end
		conclude;
	end
	initial begin
		#20000;
		err_count = err_count + 1;
		conclude;
	end
endmodule // instruction_cycle_phase_timing_tb
